// ### testbench.sv
// Self-checking bench for the UART transmit channel.
// Assumes osTick is made here every other cycle: 32 clk per bit at 16x.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module testbench;
  import uart_tx_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  regReq_t regReq = '0;
  logic osTick = 1'b0;
  flowEvt_t flowEvt = '0;
  logic [7:0] rxLevel = 8'h37;
  logic [7:0] monBit = 8'h20;
  logic parEn = 1'b0;
  logic [7:0] rdData, rxTrigger, monData;
  logic serialOut, dirOut, irq, monPar, monStop, monDone;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  // Clock and oversample pulse; a slow tick keeps the bit count honest
  always #4 clk = ~clk;
  always @(posedge clk) osTick <= ~osTick;

  uart_tx_chan #(.DEPTH(TX_DEPTH)) dut (.clk(clk), .sys_rst(sysRst),
    .regReq(regReq), .rdData(rdData), .osTick(osTick), .flowEvt(flowEvt),
    .rxLevel(rxLevel), .rxTrigger(rxTrigger), .serialOut(serialOut),
    .dirOut(dirOut), .irq(irq));

  uart_line_monitor mon (.clk(clk), .line(serialOut), .bitCycles(monBit),
    .parEn(parEn), .rxData(monData), .parBit(monPar), .stopOk(monStop),
    .done(monDone));

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bus cycles: strobe for one edge, then idle for one
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e,
                       input string what);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1 chk(rdData, e, what);
  endtask

  task automatic bitIs(input logic b, input logic e, input string what);
    chk({7'h00, b}, {7'h00, e}, what);
  endtask

  task automatic irqIs(input logic e, input string what);
    repeat (2) @(posedge clk);
    #1 bitIs(irq, e, what);
  endtask

  // Bounded wait for the monitor to finish a character
  task automatic waitChar(input logic [7:0] e);
    int k;
    k = 0;
    @(posedge clk);
    while (monDone !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    // A frame that never ends would leave stale data behind
    if (k >= 2000) begin
      n_mismatch++;
      $display("ERROR %0t char timeout", $time);
    end
    chk(monData, e, "char data");
  endtask

  // Send one byte and time data bit 0 (bit 0 one, bit 1 zero); the start
  // bit is skipped as its length depends on the tick phase at load
  task automatic sendTimed(input logic [7:0] d, input int len);
    int n;
    n = 0;
    wr(OFF_HOLD, d);
    while (serialOut !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (serialOut === 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (serialOut === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(8'(n), 8'(len), "bit length");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rdChk(OFF_LSTAT, 8'h60, "lsr reset");
    rdChk(OFF_ISTAT, 8'h01, "isr reset");
    rdChk(5'h1f, 8'h00, "unmapped");
    bitIs(serialOut, 1'b1, "idle");
  endtask

  task automatic tPlain;
    wr(OFF_LCTRL, 8'h03);
    wr(OFF_EVMASK, 8'h02);
    sendTimed(8'hA5, 32);
    rdChk(OFF_LSTAT, 8'h20, "lsr busy");
    waitChar(8'hA5);
    bitIs(monStop, 1'b1, "stop bit");
    repeat (20) @(posedge clk);
    rdChk(OFF_LSTAT, 8'h60, "lsr done");
    bitIs(serialOut, 1'b1, "idle after");
    bitIs(irq, 1'b1, "event irq");
    wr(OFF_EVSTAT, 8'h07);
    irqIs(1'b0, "event cleared");
    wr(OFF_IEN, 8'h02);
    irqIs(1'b1, "thr empty irq");
    rdChk(OFF_ISTAT, 8'h02, "isr txe");
    wr(OFF_IEN, 8'h00);
    wr(OFF_EVMASK, 8'h00);
  endtask

  task automatic tParity;
    wr(OFF_CFG, 8'h01);
    wr(OFF_LCTRL, 8'h1B);
    monBit <= 8'd16;
    parEn <= 1'b1;
    sendTimed(8'h0D, 16);
    waitChar(8'h0D);
    bitIs(monPar, 1'b1, "even parity");
    repeat (12) @(posedge clk);
    wr(OFF_CFG, 8'h00);
    wr(OFF_LCTRL, 8'h03);
    monBit <= 8'd32;
    parEn <= 1'b0;
  endtask

  task automatic tFifo;
    wr(OFF_ISTAT, 8'h01);
    wr(OFF_TXLVL, 8'h02);
    wr(OFF_IEN, 8'h02);
    irqIs(1'b1, "below trigger");
    wr(OFF_HOLD, 8'h11);
    wr(OFF_HOLD, 8'h22);
    wr(OFF_HOLD, 8'h33);
    rdChk(OFF_TXLVL, 8'h02, "tx level");
    rdChk(OFF_LSTAT, 8'h00, "fifo busy");
    bitIs(irq, 1'b0, "at trigger");
    waitChar(8'h11);
    waitChar(8'h22);
    waitChar(8'h33);
    repeat (20) @(posedge clk);
    rdChk(OFF_LSTAT, 8'h60, "fifo empty");
    rdChk(OFF_ISTAT, 8'hC2, "isr fifo");
    wr(OFF_IEN, 8'h00);
  endtask

  task automatic tAuto;
    int n;
    wr(OFF_IEN, 8'hE2);
    rdChk(OFF_IEN, 8'h02, "gated ier");
    wr(OFF_EFCTRL, 8'h10);
    wr(OFF_MSTAT, 8'h20);
    wr(OFF_FEAT, 8'h20);
    wr(OFF_IEN, 8'h02);
    wr(OFF_HOLD, 8'h5A);
    repeat (40) @(posedge clk);
    #1 bitIs(dirOut, 1'b1, "dir sending");
    bitIs(irq, 1'b0, "no irq busy");
    waitChar(8'h5A);
    n = 0;
    while (dirOut === 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n_compared++;
    if (n < 74 || n > 86) begin
      n_mismatch++;
      $display("ERROR %0t direction hold %0d cycles", $time, n);
    end
    irqIs(1'b1, "shifter empty irq");
    wr(OFF_FEAT, 8'h00);
    wr(OFF_IEN, 8'h00);
  endtask

  task automatic tMisc;
    wr(OFF_MCTRL, 8'h0C);
    rdChk(OFF_MCTRL, 8'h0C, "gp bits");
    bitIs(dirOut, 1'b0, "gp no pin");
    wr(OFF_MCTRL, 8'h02);
    #1 bitIs(dirOut, 1'b1, "rts bit");
    wr(OFF_MCTRL, 8'h00);
    @(posedge clk);
    flowEvt <= '{txXon: 1'b1, txXoff: 1'b0, detXon: 1'b1, detXoff: 1'b0};
    @(posedge clk);
    flowEvt <= '0;
    rdChk(OFF_XCHAR, 8'h0A, "flow flags");
    rdChk(OFF_XCHAR, 8'h00, "flow cleared");
    rdChk(OFF_RXLVL, 8'h37, "rx level");
    wr(OFF_RXLVL, 8'h44);
    #1 chk(rxTrigger, 8'h44, "rx trigger");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("ERROR %0t timeout", $time);
      conclude;
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    tReset;
    tPlain;
    tParity;
    tFifo;
    tAuto;
    tMisc;
    conclude;
  end
endmodule // testbench

// ### uart_line_monitor.sv
// Partner model: a serial receiver listening on the transmit line.
// Assumes the line idles high and bit length is given in clk cycles.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module uart_line_monitor (
  // Clock
  input wire logic clk,
  // Line and framing setup
  input wire logic line,
  input wire logic [7:0] bitCycles,
  input wire logic parEn,
  // Decoded character
  output logic [7:0] rxData,
  output logic parBit,
  output logic stopOk,
  output logic done
);
  logic [7:0] shiftIn;

  // Quiet outputs until the first frame
  initial begin
    rxData = 8'h00;
    parBit = 1'b0;
    stopOk = 1'b0;
    done = 1'b0;
    shiftIn = 8'h00;
  end

  // Sample mid-bit on falling edges, clear of line updates
  always begin
    @(negedge clk);
    if (line === 1'b0) begin
      repeat (bitCycles / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitCycles) @(negedge clk);
        shiftIn[i] = line;
      end
      if (parEn) begin
        repeat (bitCycles) @(negedge clk);
        parBit = line;
      end
      repeat (bitCycles) @(negedge clk);
      stopOk = line;
      rxData = shiftIn;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
    end
  end
endmodule // uart_line_monitor

// ### uart_tx_chan.sv
// UART channel transmit path: FIFO, holding and shift registers, status,
// transmit-empty interrupt and automatic half-duplex direction control.
// Assumes osTick is a one-cycle pulse at 16x or 8x the bit rate, made by
// an outside baud generator; receiver and flow-control logic are outside.
//
// Overview of operation
// (RULE1) 256-byte FIFO, holding register and shift register feed the line.
// (RULE2) One serial bit lasts 16 or 8 oversample ticks.
// (RULE3) Frame: start, data bits, optional parity, then stop bits.
// (RULE4) Data bit zero goes out first after the start bit.
// (RULE5) FIFO enabled: writes push the FIFO; else they load the holding reg.
// (RULE6) Non-FIFO: holding-empty sets when the byte moves to the shifter.
// (RULE7) Shifter-empty sets only after the last stop bit has gone.
// (RULE8) Non-FIFO: holding-empty raises transmit-empty interrupt when enabled.
// (RULE9) FIFO mode: holding-empty flag shows an empty FIFO.
// (RULE10) FIFO mode: interrupt while level is below the trigger level.
// (RULE11) Auto direction mode: interrupt source becomes shifter-empty.
// (RULE12) Auto direction mode: direction drops a set delay after last stop.
// (RULE13) Flow-char status: upper nibble zero, four flags clear on read.
// (RULE14) General output bits 3 and 2 drive no pins.
// (RULE15) Enhanced-feature bit 4 gates the extended register bits.
// (RULE16) Level reads and trigger writes share one index per direction.
// (RULE17) Line idles high between characters.
// (RULE18) Host checks empty flag or level before writing more data.
`timescale 1ns/1ps

module uart_tx_chan #(
  parameter int DEPTH = uart_tx_pkg::TX_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input uart_tx_pkg::regReq_t regReq,
  output logic [7:0] rdData,
  // Baud and flow-control events from neighbours
  input wire logic osTick,
  input uart_tx_pkg::flowEvt_t flowEvt,
  input wire logic [7:0] rxLevel,
  output logic [7:0] rxTrigger,
  // Line side
  output logic serialOut,
  output logic dirOut,
  output logic irq
);
  import uart_tx_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [7:0] ier_ff, fcr_ff, lcr_ff, mcr_ff, msr_ff, scratch_ff;
  logic [7:0] feature_control_reg_ff, efr_ff, txTrig_ff, rxTrig_ff;
  logic [7:0] pause1_ff, pause2_ff, resume1_ff, resume2_ff;
  logic [7:0] evMask_ff, cfg_ff, rdData_ff;
  logic [2:0] evStat_ff;
  logic [3:0] xchar_ff;
  logic [7:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_ff, rdPtr_ff;
  logic [PW:0] count_ff;
  logic [7:0] thr_ff, shift_ff, loaded_ff;
  logic thrValid_ff;
  txState_t state_ff;
  logic [3:0] tickCnt_ff, dlyCnt_ff;
  logic [2:0] bitIdx_ff;
  logic stopLeft_ff, dirActive_ff, dlyRun_ff, serialOut_ff, srcEmpty_ff;
  logic wrEn, rdEn, wrHold, fifoMode, autoDir, enh, fifoFull, fifoEmpty;
  logic push, load, pop, bitEnd, charDone, thre, temt, srcEmpty;
  logic txeInt, dirRelease, txRstReq;
  logic [3:0] tickLast;
  logic [2:0] lastBit;
  logic [7:0] loadByte, txLevel, rdMux;
  logic parBit, nxtSerial;

  ////////////////////////////////////////////////////////////////////////
  // Decode and mode terms

  assign wrEn = regReq.wr;
  assign rdEn = regReq.rd;
  assign wrHold = wrEn && regReq.addr == OFF_HOLD;
  assign txRstReq = wrEn && regReq.addr == OFF_ISTAT &&
                    regReq.wdata[FCR_TX_RST];
  assign fifoMode = fcr_ff[FCR_FIFO_EN];
  assign autoDir = feature_control_reg_ff[FEATURE_CONTROL_REG_AUTO485];
  assign enh = efr_ff[EFR_ENH];
  assign fifoFull = count_ff == (PW+1)'(DEPTH);
  assign fifoEmpty = count_ff == '0;
  assign tickLast = cfg_ff[CFG_OS8] ? OS8_LAST : OS16_LAST;
  assign lastBit = 3'(3'd4 + {1'b0, lcr_ff[1:0]});
  assign bitEnd = osTick && tickCnt_ff == tickLast;
  // Clamp: a full FIFO of 256 cannot show in eight bits
  assign txLevel = count_ff[PW] ? 8'hff : count_ff[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Control registers; extended bits only writable with enhanced on

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ier_ff <= REG_RST;
      fcr_ff <= REG_RST;
      lcr_ff <= REG_RST;
      mcr_ff <= REG_RST;
      msr_ff <= REG_RST;
      scratch_ff <= REG_RST;
      feature_control_reg_ff <= REG_RST;
      efr_ff <= REG_RST;
      cfg_ff <= REG_RST;
      evMask_ff <= REG_RST;
    end else if (wrEn) begin
      case (regReq.addr)
        OFF_IEN: ier_ff <= enh ? regReq.wdata :
          (ier_ff & IER_ENH_MASK) | (regReq.wdata & ~IER_ENH_MASK); // see RULE15
        OFF_ISTAT: fcr_ff <= enh ? regReq.wdata :
          (fcr_ff & FCR_ENH_MASK) | (regReq.wdata & ~FCR_ENH_MASK); // see RULE15
        OFF_LCTRL: lcr_ff <= regReq.wdata;
        // Bits 3:2 are storage only, no pin behind them
        OFF_MCTRL: mcr_ff <= enh ? regReq.wdata :
          (mcr_ff & MCR_ENH_MASK) | (regReq.wdata & ~MCR_ENH_MASK); // see RULE14
        OFF_MSTAT: if (enh) msr_ff <= regReq.wdata; // see RULE15
        OFF_SCRATCH: scratch_ff <= regReq.wdata;
        OFF_FEAT: feature_control_reg_ff <= regReq.wdata;
        OFF_EFCTRL: efr_ff <= regReq.wdata;
        OFF_EVMASK: evMask_ff <= regReq.wdata;
        OFF_CFG: cfg_ff <= regReq.wdata;
        default: ;
      endcase
    end
  end

  // Write-only trigger and character registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txTrig_ff <= TX_FIFO_TRIGGER_RST;
      rxTrig_ff <= REG_RST;
      pause1_ff <= REG_RST;
      pause2_ff <= REG_RST;
      resume1_ff <= REG_RST;
      resume2_ff <= REG_RST;
    end else if (wrEn) begin
      case (regReq.addr)
        OFF_TXLVL: txTrig_ff <= regReq.wdata; // see RULE16
        OFF_RXLVL: rxTrig_ff <= regReq.wdata; // see RULE16
        OFF_XCHAR: pause1_ff <= regReq.wdata;
        OFF_PAUSE2: pause2_ff <= regReq.wdata;
        OFF_RESUME1: resume1_ff <= regReq.wdata;
        OFF_RESUME2: resume2_ff <= regReq.wdata;
        default: ;
      endcase
    end
  end

  assign rxTrigger = rxTrig_ff;

  ////////////////////////////////////////////////////////////////////////
  // Transmit FIFO; a full FIFO drops the byte, so the host must poll

  assign push = wrHold && fifoMode && !fifoFull; // see RULE5 RULE18
  assign pop = load && fifoMode;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_ff] <= regReq.wdata; // see RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || txRstReq) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Holding register, used directly only outside FIFO mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thr_ff <= REG_RST;
      thrValid_ff <= 1'b0;
    end else if (wrHold && !fifoMode) begin
      thr_ff <= regReq.wdata; // see RULE5
      thrValid_ff <= 1'b1;
    end else if (load) begin
      thrValid_ff <= 1'b0; // see RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift register and framing

  assign load = state_ff == ST_IDLE &&
                (fifoMode ? !fifoEmpty : thrValid_ff);
  assign loadByte = fifoMode ? mem[rdPtr_ff] : thr_ff;
  assign charDone = state_ff == ST_STOP && bitEnd && !stopLeft_ff;
  // Stick parity sends the inverse of the even-select bit
  assign parBit = lcr_ff[LCR_STICK] ? !lcr_ff[LCR_EVEN] :
                  (lcr_ff[LCR_EVEN] ? ^loaded_ff : ~^loaded_ff);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= REG_RST;
      loaded_ff <= REG_RST;
      bitIdx_ff <= '0;
      stopLeft_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: if (load) begin
          shift_ff <= loadByte;
          loaded_ff <= loadByte;
          state_ff <= ST_START; // see RULE3
        end
        ST_START: if (bitEnd) begin
          bitIdx_ff <= '0;
          state_ff <= ST_DATA;
        end
        ST_DATA: if (bitEnd) begin
          shift_ff <= {1'b0, shift_ff[7:1]}; // see RULE4
          bitIdx_ff <= bitIdx_ff + 1'b1;
          if (bitIdx_ff == lastBit) begin
            state_ff <= lcr_ff[LCR_PAR_EN] ? ST_PAR : ST_STOP; // see RULE3
            stopLeft_ff <= lcr_ff[LCR_STOP2];
          end
        end
        ST_PAR: if (bitEnd) state_ff <= ST_STOP;
        ST_STOP: if (bitEnd) begin
          if (stopLeft_ff) stopLeft_ff <= 1'b0;
          else state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Oversample counter, shared with the turn-around delay
  always_ff @(posedge clk) begin
    if (sys_rst || load || (state_ff == ST_IDLE && !dlyRun_ff)) begin
      tickCnt_ff <= '0;
    end else if (osTick) begin
      tickCnt_ff <= bitEnd ? 4'h0 : tickCnt_ff + 1'b1; // see RULE2
    end
  end

  // Line level; break forces low, loopback keeps the pin idle
  always_comb begin
    case (state_ff)
      ST_START: nxtSerial = 1'b0;
      ST_DATA: nxtSerial = shift_ff[0];
      ST_PAR: nxtSerial = parBit;
      default: nxtSerial = 1'b1; // see RULE17
    endcase
    if (lcr_ff[LCR_BREAK]) nxtSerial = 1'b0;
    if (mcr_ff[MCR_LOOP]) nxtSerial = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) serialOut_ff <= 1'b1;
    else serialOut_ff <= nxtSerial;
  end

  assign serialOut = serialOut_ff;

  ////////////////////////////////////////////////////////////////////////
  // Status flags and transmit-empty interrupt

  assign thre = fifoMode ? fifoEmpty : !thrValid_ff; // see RULE6 RULE9
  assign temt = thre && state_ff == ST_IDLE; // see RULE7
  always_comb begin
    if (autoDir) srcEmpty = temt; // see RULE11
    else if (fifoMode) srcEmpty = count_ff < {1'b0, txTrig_ff}; // see RULE10
    else srcEmpty = thre; // see RULE8
  end
  assign txeInt = ier_ff[IER_TXE] && srcEmpty; // see RULE8 RULE10

  ////////////////////////////////////////////////////////////////////////
  // Direction control: held through the last stop plus the delay

  assign dirRelease = dlyRun_ff ? (bitEnd && dlyCnt_ff == 4'h1) :
                      (charDone && !load && thre && msr_ff[7:4] == 4'h0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dirActive_ff <= 1'b0;
      dlyRun_ff <= 1'b0;
      dlyCnt_ff <= '0;
    end else if (load) begin
      dirActive_ff <= 1'b1;
      dlyRun_ff <= 1'b0;
    end else if (charDone && thre && msr_ff[7:4] != 4'h0) begin
      dlyRun_ff <= 1'b1; // see RULE12
      dlyCnt_ff <= msr_ff[7:4];
    end else if (dirRelease) begin
      dirActive_ff <= 1'b0; // see RULE12
      dlyRun_ff <= 1'b0;
    end else if (dlyRun_ff && bitEnd) begin
      dlyCnt_ff <= dlyCnt_ff - 1'b1;
    end
  end

  assign dirOut = autoDir ? dirActive_ff : mcr_ff[MCR_RTS];

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xchar_ff <= '0;
      evStat_ff <= '0;
      srcEmpty_ff <= 1'b0;
    end else begin
      srcEmpty_ff <= srcEmpty;
      xchar_ff <= (rdEn && regReq.addr == OFF_XCHAR ? 4'h0 : xchar_ff) |
                  flowEvt; // see RULE13
      evStat_ff <= (wrEn && regReq.addr == OFF_EVSTAT ?
                    evStat_ff & ~regReq.wdata[2:0] : evStat_ff) |
                   {dirRelease && autoDir, charDone, srcEmpty &&
                    !srcEmpty_ff};
    end
  end

  assign irq = |(evStat_ff & evMask_ff[2:0]) || txeInt;

  ////////////////////////////////////////////////////////////////////////
  // Read path, data stands the cycle after the strobe

  always_comb begin
    case (regReq.addr)
      OFF_IEN: rdMux = ier_ff;
      OFF_ISTAT: rdMux = {{2{fifoMode}}, 2'b00,
                          txeInt ? ISR_TXE : ISR_NONE};
      OFF_LCTRL: rdMux = lcr_ff;
      OFF_MCTRL: rdMux = mcr_ff;
      OFF_LSTAT: rdMux = {1'b0, temt, thre, 5'h00};
      OFF_SCRATCH: rdMux = scratch_ff;
      OFF_FEAT: rdMux = feature_control_reg_ff;
      OFF_EFCTRL: rdMux = efr_ff;
      OFF_TXLVL: rdMux = txLevel; // see RULE16
      OFF_RXLVL: rdMux = rxLevel; // see RULE16
      OFF_XCHAR: rdMux = {4'h0, xchar_ff}; // see RULE13
      OFF_EVSTAT: rdMux = {5'h00, evStat_ff};
      OFF_EVMASK: rdMux = evMask_ff;
      OFF_CFG: rdMux = cfg_ff;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rdData_ff <= 8'h00;
    else if (rdEn) rdData_ff <= rdMux;
  end

  assign rdData = rdData_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_start_bit_low: assert property ( // see RULE3
    (state_ff == ST_START && !lcr_ff[LCR_BREAK] && !mcr_ff[MCR_LOOP])
    |=> !serialOut_ff) else $error("start bit not low");
  a_idle_line_high: assert property ( // see RULE17
    (state_ff == ST_IDLE && !lcr_ff[LCR_BREAK] && !mcr_ff[MCR_LOOP])
    |=> serialOut_ff) else $error("idle line not high");
  a_lsb_first: assert property ( // see RULE4
    (state_ff == ST_DATA && bitIdx_ff == 3'd0)
    |-> shift_ff[0] == loaded_ff[0]) else $error("first data bit not lsb");
  a_bit_period: assert property ( // see RULE2
    (state_ff != ST_IDLE && !(osTick && tickCnt_ff == tickLast))
    |=> state_ff == $past(state_ff)) else $error("bit ended early");
  a_fifo_push: assert property ( // see RULE5
    (push && !txRstReq) |=> count_ff == $past(count_ff) + 1'b1 -
    (PW+1)'($past(pop))) else $error("push not counted");
  a_hold_empty: assert property ( // see RULE6
    (!fifoMode && thrValid_ff && load) |=> !thrValid_ff || $past(wrHold))
    else $error("holding empty not set on load");
  a_fifo_thre: assert property ( // see RULE9
    (fifoMode && !fifoEmpty) |-> !thre) else $error("thre with data");
  a_temt_idle: assert property ( // see RULE7
    (state_ff == ST_STOP) |-> !temt) else $error("temt before stop end");
  a_auto_src: assert property ( // see RULE11
    (autoDir && state_ff != ST_IDLE) |-> !txeInt)
    else $error("auto mode interrupt before shifter empty");
  a_dir_hold: assert property ( // see RULE12
    (autoDir && state_ff == ST_STOP) |-> dirOut) else $error("dir dropped");
  a_xchar_clear: assert property ( // see RULE13
    (rdEn && regReq.addr == OFF_XCHAR && flowEvt == 4'h0) |=> xchar_ff == 4'h0)
    else $error("flow flags not cleared");
  a_enh_gate: assert property ( // see RULE15
    (wrEn && regReq.addr == OFF_IEN && !enh)
    |=> ier_ff[7:5] == $past(ier_ff[7:5])) else $error("ier gated bits");

  c_parity_frame: cover property (state_ff == ST_PAR ##[1:300] charDone);
  c_fifo_full: cover property (fifoFull);
  c_dir_delay: cover property (dlyRun_ff ##[1:1000] dirRelease);
  c_xchar_read: cover property (rdEn && regReq.addr == OFF_XCHAR &&
                                xchar_ff != 4'h0);

endmodule // uart_tx_chan

// ### uart_tx_pkg.sv
// Package for the UART transmit channel: register map, fields, types.
// Assumes a 5-bit register index with 8-bit data on a plain strobe port.
package uart_tx_pkg;

  // Register indices (holding, FIFO control and trigger pairs share)
  localparam logic [4:0] OFF_HOLD = 5'h00;
  localparam logic [4:0] OFF_IEN = 5'h01;
  localparam logic [4:0] OFF_ISTAT = 5'h02;
  localparam logic [4:0] OFF_LCTRL = 5'h03;
  localparam logic [4:0] OFF_MCTRL = 5'h04;
  localparam logic [4:0] OFF_LSTAT = 5'h05;
  localparam logic [4:0] OFF_MSTAT = 5'h06;
  localparam logic [4:0] OFF_SCRATCH = 5'h07;
  localparam logic [4:0] OFF_FEAT = 5'h08;
  localparam logic [4:0] OFF_EFCTRL = 5'h09;
  localparam logic [4:0] OFF_TXLVL = 5'h0a;
  localparam logic [4:0] OFF_RXLVL = 5'h0b;
  localparam logic [4:0] OFF_XCHAR = 5'h0c;
  localparam logic [4:0] OFF_PAUSE2 = 5'h0d;
  localparam logic [4:0] OFF_RESUME1 = 5'h0e;
  localparam logic [4:0] OFF_RESUME2 = 5'h0f;
  localparam logic [4:0] OFF_EVSTAT = 5'h10;
  localparam logic [4:0] OFF_EVMASK = 5'h11;
  localparam logic [4:0] OFF_CFG = 5'h12;

  // Field positions
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_TX_RST = 2;
  localparam int IER_TXE = 1;
  localparam int EFR_ENH = 4;
  localparam int FEATURE_CONTROL_REG_AUTO485 = 5;
  localparam int LSR_THRE = 5;
  localparam int LSR_TEMT = 6;
  localparam int MCR_RTS = 1;
  localparam int MCR_LOOP = 4;
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BREAK = 6;
  localparam int CFG_OS8 = 0;
  localparam int EV_TXE = 0;
  localparam int EV_CHAR = 1;
  localparam int EV_DIR = 2;

  // Bits that only exist while the enhanced-feature enable is set
  localparam logic [7:0] IER_ENH_MASK = 8'he0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;

  // Reset values and codes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] TX_FIFO_TRIGGER_RST = 8'h01;
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_TXE = 4'h2;
  localparam logic [3:0] OS16_LAST = 4'hf;
  localparam logic [3:0] OS8_LAST = 4'h7;
  localparam int TX_DEPTH = 256;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } txState_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regReq_t;

  typedef struct packed {
    logic txXon;
    logic txXoff;
    logic detXon;
    logic detXoff;
  } flowEvt_t;

endpackage
